//--- bench/serial_port_zero_control_asserts.sv
// Port checks for the serial port zero control block
`timescale 1ns/1ps
`default_nettype none
module serial_port_zero_control_asserts (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic rxd_in,
	input wire logic rxd_out,
	input wire logic rxd_oe,
	input wire logic txd,
	input wire logic irq
);
	logic wr_r;
	logic [7:0] wa_r;
	logic [3:0] lo_r;
	wire logic rd_go = hsel && htrans[1] && !hwrite && hready;
	wire logic [7:0] a8 = haddr[7:0];
	// Write data phase tracking and shift clock low run length
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wr_r <= 1'b0;
			wa_r <= 8'h00;
			lo_r <= 4'h0;
		end else begin
			wr_r <= hsel && htrans[1] && hwrite && hready;
			wa_r <= a8;
			lo_r <= txd ? 4'h0 : lo_r + 4'h1;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	a_ready_high: assert property ($past(rstn) |-> hreadyout)
		else $error("slave stalled the bus");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("error response seen");
	a_rdata_upper: assert property (hrdata[31:16] == 16'h0000)
		else $error("read data upper bits not zero");
	a_rdata_holds: assert property (!$past(rd_go) |-> $stable(hrdata))
		else $error("read data changed without a read");
	a_unmapped_zero: assert property (
		rd_go && (a8 > 8'hac || a8 < 8'h98 || a8[1:0] != 2'b00)
		|=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_mask_off_quiet: assert property (
		wr_r && wa_r == serial_port_zero_pkg::OFF_IRQ_MASK &&
		hwdata[2:0] == 3'h0 |=> ##1 !irq)
		else $error("interrupt raised with all sources masked");
	a_data_on_fall: assert property (
		rxd_oe && $past(rxd_oe) && $changed(rxd_out) |-> !txd)
		else $error("shift data changed while clock high");
	a_half_bound: assert property (rxd_oe && !txd |-> lo_r < 4'h6)
		else $error("shift clock low phase too long");
endmodule
`default_nettype wire

//--- bench/serial_port_zero_control_bench.sv
// Self-checking bench for the serial port zero control block
`timescale 1ns/1ps
`default_nettype none
module serial_port_zero_control_bench;
	localparam logic [7:0] A_CTL = serial_port_zero_pkg::OFF_CONTROL;
	localparam logic [7:0] A_BUF = serial_port_zero_pkg::OFF_BUFFER;
	localparam logic [7:0] A_PWR = serial_port_zero_pkg::OFF_POWER;
	localparam logic [7:0] A_STS = serial_port_zero_pkg::OFF_IRQ_STATUS;
	localparam logic [7:0] A_MSK = serial_port_zero_pkg::OFF_IRQ_MASK;
	localparam logic [7:0] A_BAUD = serial_port_zero_pkg::OFF_BAUD;
	logic sys_clk, rstn, hsel, hwrite, hreadyout, hresp, rxd_out, rxd_oe;
	logic txd, irq, r_line, cn, cs;
	logic [31:0] haddr, hwdata, hrdata, rdv;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [7:0] cd, m0d;
	wire logic rxd_pin = rxd_oe ? rxd_out : r_line;
	int failures = 0, checks = 0, cycles = 0, lo;
	logic [7:0] t_ctl [4] = '{8'h88, 8'h80, 8'hc8, 8'h40};
	logic [7:0] t_pwr [4] = '{8'h80, 8'h00, 8'h80, 8'h00};
	logic [7:0] t_dat [4] = '{8'ha5, 8'h5a, 8'h3e, 8'hc1};
	int t_bt [4] = '{32, 64, 16, 32};
	serial_port_zero_control u_serial_port_zero_control (
		.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .rxd_in(rxd_pin), .rxd_out(rxd_out),
		.rxd_oe(rxd_oe), .txd(txd), .irq(irq)
	);
	serial_remote_model u_serial_remote_model (
		.sys_clk(sys_clk), .txd(txd), .rx_line(r_line)
	);
	task automatic close_out;
		if (failures == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		@(posedge sys_clk);
		while (!hreadyout) @(posedge sys_clk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge sys_clk);
		while (!hreadyout) @(posedge sys_clk);
		rdv = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] exp,
		input logic [31:0] m = 32'hffffffff);
		bus(1'b0, a, 32'h0);
		chk(rdv & m, exp);
	endtask
	// Shift clock low time of first bit and data sampled on rising clock
	task automatic m0_watch(output int low, output logic [7:0] d);
		int k;
		k = 0;
		low = 0;
		for (int i = 0; i < 8; i++) begin
			while (txd && k < 500) begin
				@(posedge sys_clk);
				k++;
			end
			while (!txd && k < 500) begin
				@(posedge sys_clk);
				k++;
				if (i == 0)
					low++;
			end
			d[i] = rxd_out;
		end
	endtask
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			close_out;
		end
	end
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	initial begin
		rstn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
		rc(A_CTL, 32'h0);
		rc(A_PWR, 32'h0);
		rc(A_STS, 32'h0);
		rc(A_MSK, 32'h0);
		rc(A_BAUD, 32'hd9);
		rc(8'hb0, 32'h0);
		wr(A_BAUD, 32'h10);
		wr(A_MSK, 32'h7);
		for (int i = 0; i < 4; i++) begin
			wr(A_PWR, {24'h0, t_pwr[i]});
			wr(A_CTL, {24'h0, t_ctl[i]});
			fork
				u_serial_remote_model.capture(t_bt[i], t_ctl[i][7], cd, cn, cs);
				wr(A_BUF, {24'h0, t_dat[i]});
			join
			chk({24'h0, cd}, {24'h0, t_dat[i]});
			chk({30'h0, cn, cs}, {30'h0, t_ctl[i][7] & t_ctl[i][3], 1'b1});
			rc(A_CTL, {24'h0, t_ctl[i] | 8'h02});
			chk({31'h0, irq}, 32'h1);
			wr(A_STS, 32'h7);
			repeat (2) @(posedge sys_clk);
			chk({31'h0, irq}, 32'h0);
		end
		wr(A_MSK, 32'h0);
		wr(A_PWR, 32'h0);
		wr(A_CTL, 32'hb0);
		u_serial_remote_model.send(64, 8'h3c, 1'b0, 1'b1, 1'b1);
		repeat (4) @(posedge sys_clk);
		rc(A_CTL, 32'hb0);
		u_serial_remote_model.send(64, 8'hc3, 1'b1, 1'b1, 1'b1);
		repeat (4) @(posedge sys_clk);
		rc(A_CTL, 32'hb5);
		rc(A_BUF, 32'hc3);
		chk({31'h0, irq}, 32'h0);
		wr(A_CTL, 32'ha0);
		u_serial_remote_model.send(64, 8'h55, 1'b1, 1'b1, 1'b1);
		repeat (4) @(posedge sys_clk);
		rc(A_CTL, 32'ha0);
		rc(A_BUF, 32'hc3);
		wr(A_STS, 32'h7);
		// Mode bits first: with the error enable on, bit 7 is the flag
		wr(A_CTL, 32'h70);
		wr(A_PWR, 32'hc0);
		u_serial_remote_model.send(16, 8'h81, 1'b0, 1'b0, 1'b0);
		repeat (4) @(posedge sys_clk);
		rc(A_CTL, 32'hf0, 32'hfb);
		rc(A_STS, 32'h4);
		wr(A_PWR, 32'h80);
		rc(A_CTL, 32'h70, 32'hfb);
		wr(A_CTL, 32'h50);
		u_serial_remote_model.send(16, 8'h42, 1'b0, 1'b0, 1'b1);
		repeat (4) @(posedge sys_clk);
		rc(A_CTL, 32'h55);
		rc(A_BUF, 32'h42);
		wr(A_PWR, 32'hc0);
		rc(A_CTL, 32'hd5);
		wr(A_PWR, 32'h0);
		for (int i = 0; i < 2; i++) begin
			wr(A_CTL, i ? 32'h20 : 32'h00);
			fork
				m0_watch(lo, m0d);
				wr(A_BUF, 32'h96);
			join
			chk(lo, i ? 32'd2 : 32'd6);
			chk({24'h0, m0d}, 32'h96);
			repeat (8) @(posedge sys_clk);
			rc(A_CTL, i ? 32'h22 : 32'h02);
		end
		// Mode 0 receive with idle line shifts in all ones
		wr(A_CTL, 32'h30);
		repeat (40) @(posedge sys_clk);
		rc(A_CTL, 32'h31);
		rc(A_BUF, 32'hff);
		close_out;
	end
endmodule
bind serial_port_zero_control serial_port_zero_control_asserts
	u_serial_port_zero_control_asserts (
	.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.hrdata(hrdata), .rxd_in(rxd_in), .rxd_out(rxd_out),
	.rxd_oe(rxd_oe), .txd(txd), .irq(irq)
);
`default_nettype wire

//--- bench/serial_remote_model.sv
// Behavioural remote serial station on the far end of the line
`timescale 1ns/1ps
`default_nettype none
module serial_remote_model (
	input wire logic sys_clk,
	input wire logic txd,
	output logic rx_line
);
	initial rx_line = 1'b1;
	// Sends one frame, start low, data LSB first, optional ninth, stop
	task automatic send(input int bt, input logic [7:0] d, input logic nine,
		input logic use9, input logic stop);
		logic [10:0] f;
		int n;
		f = use9 ? {stop, nine, d, 1'b0} : {1'b1, stop, d, 1'b0};
		n = use9 ? 11 : 10;
		for (int i = 0; i < n; i++) begin
			rx_line <= f[i];
			repeat (bt) @(posedge sys_clk);
		end
		rx_line <= 1'b1;
	endtask
	// Samples a frame from txd at bit centres
	task automatic capture(input int bt, input logic use9,
		output logic [7:0] d, output logic nine, output logic stop);
		int k;
		k = 0;
		nine = 1'b0;
		while (txd && k < 2000) begin
			@(posedge sys_clk);
			k++;
		end
		repeat (bt / 2) @(posedge sys_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (bt) @(posedge sys_clk);
			d[i] = txd;
		end
		if (use9) begin
			repeat (bt) @(posedge sys_clk);
			nine = txd;
		end
		repeat (bt) @(posedge sys_clk);
		stop = txd;
		// Let the stop bit finish so the next buffer write is not dropped
		repeat (bt / 2 + 2) @(posedge sys_clk);
	endtask
endmodule
`default_nettype wire

//--- core/serial_port_zero_control.sv
// Serial port zero: control register, four frame modes, AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none
module serial_port_zero_control (
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic rxd_in,
	output logic rxd_out,
	output logic rxd_oe,
	output logic txd,
	output logic irq
);
	serial_port_zero_pkg::ahb_req_t req_r;
	logic [7:0] rd_val;
	logic [7:0] wdata;
	logic take;
	logic in_map;
	logic wr_ctl, wr_buf, wr_pwr, wr_sts, wr_msk, wr_baud;
	// Control state
	logic mode_hi_r, mode_lo_r, filter_r, rx_en_r, tx9_r, rx9_r;
	logic tx_done_r, rx_done_r, fe_r;
	logic doubler_r, fe_en_r;
	logic [15:0] baud_r;
	logic [2:0] sts_r, msk_r;
	logic [7:0] rx_buf_r;
	serial_port_zero_pkg::mode_t mode;
	logic is_async;
	logic [16:0] bit_cycles, half_cycles, m0_half;
	// Receive line synchroniser
	logic rxd_s1_r, rxd_s2_r, rxd_prev_r;
	// Async transmitter
	logic tx_busy_r, tx_bit_r;
	logic [16:0] tx_cnt_r;
	logic [3:0] tx_idx_r, tx_last;
	logic [10:0] tx_sh_r;
	logic tx_tick, tx_start, tx_done_set_a;
	// Async receiver
	serial_port_zero_pkg::rx_state_t rx_st_r;
	logic [16:0] rx_cnt_r;
	logic [3:0] rx_idx_r, rx_nbits;
	logic [8:0] rx_sh_r;
	logic rx_fall, rx_full, rx_half, rx_stop_eval, stop_ok, rx_accept;
	logic [7:0] rx_data_a;
	// Mode 0 shifter
	logic m0_busy_r, m0_dir_r, m0_phase_r, m0_clk_r, m0_out_r, m0_oe_r;
	logic [16:0] m0_cnt_r;
	logic [2:0] m0_idx_r;
	logic [7:0] m0_sh_r;
	logic m0_tick, m0_start_tx, m0_start_rx, m0_end;
	logic tx_done_set, rx_done_set, fe_set;

	assign take = hsel && htrans[1] && hready;
	assign in_map = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00);
	assign wdata = hwdata[7:0];
	assign wr_ctl = req_r.valid && req_r.write
		&& req_r.addr == serial_port_zero_pkg::OFF_CONTROL;
	assign wr_buf = req_r.valid && req_r.write
		&& req_r.addr == serial_port_zero_pkg::OFF_BUFFER;
	assign wr_pwr = req_r.valid && req_r.write
		&& req_r.addr == serial_port_zero_pkg::OFF_POWER;
	assign wr_sts = req_r.valid && req_r.write
		&& req_r.addr == serial_port_zero_pkg::OFF_IRQ_STATUS;
	assign wr_msk = req_r.valid && req_r.write
		&& req_r.addr == serial_port_zero_pkg::OFF_IRQ_MASK;
	assign wr_baud = req_r.valid && req_r.write
		&& req_r.addr == serial_port_zero_pkg::OFF_BAUD;

	// Register read mux, captured in the address phase
	always_comb begin
		case (haddr[7:0])
			serial_port_zero_pkg::OFF_CONTROL: rd_val = {fe_en_r ? fe_r : mode_hi_r,
				mode_lo_r, filter_r, rx_en_r, tx9_r, rx9_r,
				tx_done_r, rx_done_r};
			serial_port_zero_pkg::OFF_BUFFER: rd_val = rx_buf_r;
			serial_port_zero_pkg::OFF_POWER: rd_val = {doubler_r, fe_en_r, 6'h00};
			serial_port_zero_pkg::OFF_IRQ_STATUS: rd_val = {5'h00, sts_r};
			serial_port_zero_pkg::OFF_IRQ_MASK: rd_val = {5'h00, msk_r};
			serial_port_zero_pkg::OFF_BAUD: rd_val = baud_r[7:0];
			default: rd_val = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			req_r <= '0;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			req_r.valid <= take && in_map;
			req_r.write <= hwrite;
			req_r.addr <= haddr[7:0];
			if (take && !hwrite) begin
				hrdata <= {24'h000000, in_map ? rd_val : 8'h00};
			end
		end
	end

	// Mode and bit timing
	assign mode = serial_port_zero_pkg::mode_t'({mode_hi_r, mode_lo_r});
	assign is_async = (mode != serial_port_zero_pkg::MODE_SHIFT);
	always_comb begin
		case (mode)
			serial_port_zero_pkg::MODE_ASYNC9_FIXED:
				bit_cycles = doubler_r ? serial_port_zero_pkg::MODE2_BIT_DOUBLE
					: serial_port_zero_pkg::MODE2_BIT_NORMAL;
			default:
				bit_cycles = doubler_r ? {1'b0, baud_r} : {baud_r, 1'b0};
		endcase
	end
	assign half_cycles = {1'b0, bit_cycles[16:1]};
	assign m0_half = filter_r ? serial_port_zero_pkg::MODE0_HALF_FAST
		: serial_port_zero_pkg::MODE0_HALF_SLOW;

	// Async transmitter
	assign tx_last = (mode == serial_port_zero_pkg::MODE_ASYNC8)
		? serial_port_zero_pkg::FRAME_LEN_10 - 4'h1
		: serial_port_zero_pkg::FRAME_LEN_11 - 4'h1;
	assign tx_start = wr_buf && is_async && !tx_busy_r;
	assign tx_tick = tx_busy_r && (tx_cnt_r == bit_cycles - 17'h00001);
	assign tx_done_set_a = tx_tick && (tx_idx_r == tx_last - 4'h1);
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			tx_busy_r <= 1'b0;
			tx_bit_r <= 1'b1;
			tx_cnt_r <= 17'h00000;
			tx_idx_r <= 4'h0;
			tx_sh_r <= 11'h7ff;
		end else if (tx_start) begin
			tx_busy_r <= 1'b1;
			tx_bit_r <= 1'b0;
			tx_cnt_r <= 17'h00000;
			tx_idx_r <= 4'h0;
			tx_sh_r <= (mode == serial_port_zero_pkg::MODE_ASYNC8)
				? {2'b11, wdata, 1'b0} : {1'b1, tx9_r, wdata, 1'b0};
		end else if (tx_tick) begin
			tx_cnt_r <= 17'h00000;
			if (tx_idx_r == tx_last) begin
				tx_busy_r <= 1'b0;
			end else begin
				tx_idx_r <= tx_idx_r + 4'h1;
				tx_sh_r <= {1'b1, tx_sh_r[10:1]};
				tx_bit_r <= tx_sh_r[1];
			end
		end else if (tx_busy_r) begin
			tx_cnt_r <= tx_cnt_r + 17'h00001;
		end
	end

	// Receive line synchroniser and edge detect
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rxd_s1_r <= 1'b1;
			rxd_s2_r <= 1'b1;
			rxd_prev_r <= 1'b1;
		end else begin
			rxd_s1_r <= rxd_in;
			rxd_s2_r <= rxd_s1_r;
			rxd_prev_r <= rxd_s2_r;
		end
	end

	// Async receiver
	assign rx_fall = rxd_prev_r && !rxd_s2_r;
	assign rx_full = (rx_cnt_r == bit_cycles - 17'h00001);
	assign rx_half = (rx_cnt_r == half_cycles - 17'h00001);
	assign rx_nbits = (mode == serial_port_zero_pkg::MODE_ASYNC8)
		? serial_port_zero_pkg::DATA_LEN_8 : serial_port_zero_pkg::DATA_LEN_9;
	assign rx_stop_eval = (rx_st_r == serial_port_zero_pkg::RX_STOP)
		&& rx_full && rx_en_r;
	assign stop_ok = rxd_s2_r;
	assign rx_data_a = (mode == serial_port_zero_pkg::MODE_ASYNC8)
		? rx_sh_r[8:1] : rx_sh_r[7:0];
	assign rx_accept = (mode == serial_port_zero_pkg::MODE_ASYNC8)
		? !(filter_r && !stop_ok)
		: !(filter_r && !rx_sh_r[8]);
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rx_st_r <= serial_port_zero_pkg::RX_IDLE;
			rx_cnt_r <= 17'h00000;
			rx_idx_r <= 4'h0;
			rx_sh_r <= 9'h000;
		end else if (!rx_en_r || !is_async) begin
			rx_st_r <= serial_port_zero_pkg::RX_IDLE;
		end else begin
			rx_cnt_r <= rx_cnt_r + 17'h00001;
			case (rx_st_r)
				serial_port_zero_pkg::RX_IDLE: begin
					rx_cnt_r <= 17'h00000;
					if (rx_fall) begin
						rx_st_r <= serial_port_zero_pkg::RX_START;
					end
				end
				serial_port_zero_pkg::RX_START: begin
					if (rx_half) begin
						rx_cnt_r <= 17'h00000;
						rx_idx_r <= 4'h0;
						rx_st_r <= rxd_s2_r ? serial_port_zero_pkg::RX_IDLE
							: serial_port_zero_pkg::RX_DATA;
					end
				end
				serial_port_zero_pkg::RX_DATA: begin
					if (rx_full) begin
						rx_cnt_r <= 17'h00000;
						rx_sh_r <= {rxd_s2_r, rx_sh_r[8:1]};
						rx_idx_r <= rx_idx_r + 4'h1;
						if (rx_idx_r == rx_nbits - 4'h1) begin
							rx_st_r <= serial_port_zero_pkg::RX_STOP;
						end
					end
				end
				serial_port_zero_pkg::RX_STOP: begin
					if (rx_full) begin
						rx_st_r <= serial_port_zero_pkg::RX_IDLE;
					end
				end
				default: rx_st_r <= serial_port_zero_pkg::RX_IDLE;
			endcase
		end
	end

	// Mode 0 synchronous shifter, data on rxd pins, clock on txd
	assign m0_start_tx = wr_buf && !is_async && !m0_busy_r;
	assign m0_start_rx = !is_async && rx_en_r && !rx_done_r
		&& !m0_busy_r && !wr_buf;
	assign m0_tick = m0_busy_r && (m0_cnt_r == m0_half - 17'h00001);
	assign m0_end = m0_tick && m0_phase_r && (m0_idx_r == serial_port_zero_pkg::SHIFT_LAST);
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			m0_busy_r <= 1'b0;
			m0_dir_r <= 1'b0;
			m0_phase_r <= 1'b0;
			m0_clk_r <= 1'b1;
			m0_out_r <= 1'b1;
			m0_oe_r <= 1'b0;
			m0_cnt_r <= 17'h00000;
			m0_idx_r <= 3'h0;
			m0_sh_r <= 8'h00;
		end else if (m0_start_tx || m0_start_rx) begin
			m0_busy_r <= 1'b1;
			m0_dir_r <= m0_start_rx;
			m0_phase_r <= 1'b0;
			m0_clk_r <= 1'b0;
			m0_cnt_r <= 17'h00000;
			m0_idx_r <= 3'h0;
			m0_sh_r <= wdata;
			m0_out_r <= m0_start_rx ? 1'b1 : wdata[0];
			m0_oe_r <= m0_start_tx;
		end else if (m0_tick) begin
			m0_cnt_r <= 17'h00000;
			m0_phase_r <= !m0_phase_r;
			m0_clk_r <= !m0_phase_r;
			if (!m0_phase_r && m0_dir_r) begin
				m0_sh_r <= {rxd_s2_r, m0_sh_r[7:1]};
			end
			if (m0_end) begin
				m0_busy_r <= 1'b0;
				m0_oe_r <= 1'b0;
				m0_clk_r <= 1'b1;
			end else if (m0_phase_r) begin
				m0_idx_r <= m0_idx_r + 3'h1;
				if (!m0_dir_r) begin
					m0_sh_r <= {1'b1, m0_sh_r[7:1]};
					m0_out_r <= m0_sh_r[1];
				end
			end
		end else if (m0_busy_r) begin
			m0_cnt_r <= m0_cnt_r + 17'h00001;
		end
	end

	// Completion and error events
	assign tx_done_set = tx_done_set_a || (m0_end && !m0_dir_r);
	assign rx_done_set = (rx_stop_eval && rx_accept) || (m0_end && m0_dir_r);
	assign fe_set = rx_stop_eval && !stop_ok;

	// Control, power and interrupt registers; hardware set wins over clear
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			{mode_hi_r, mode_lo_r, filter_r, rx_en_r, tx9_r, rx9_r,
				tx_done_r, rx_done_r} <= serial_port_zero_pkg::CONTROL_RESET;
			fe_r <= 1'b0;
			{doubler_r, fe_en_r} <= serial_port_zero_pkg::POWER_RESET[7:6];
			baud_r <= serial_port_zero_pkg::BAUD_RESET;
			sts_r <= serial_port_zero_pkg::IRQ_RESET;
			msk_r <= serial_port_zero_pkg::IRQ_RESET;
			rx_buf_r <= 8'h00;
			txd <= 1'b1;
			rxd_out <= 1'b1;
			rxd_oe <= 1'b0;
			irq <= 1'b0;
		end else begin
			if (wr_ctl) begin
				if (!fe_en_r) begin
					mode_hi_r <= wdata[serial_port_zero_pkg::CTL_MODE_HI];
				end
				mode_lo_r <= wdata[serial_port_zero_pkg::CTL_MODE_LO];
				filter_r <= wdata[serial_port_zero_pkg::CTL_FILTER];
				rx_en_r <= wdata[serial_port_zero_pkg::CTL_RX_EN];
				tx9_r <= wdata[serial_port_zero_pkg::CTL_TX9];
			end
			if (rx_stop_eval && rx_accept) begin
				rx9_r <= (mode == serial_port_zero_pkg::MODE_ASYNC8)
					? (filter_r ? rx9_r : stop_ok) : rx_sh_r[8];
			end else if (wr_ctl) begin
				rx9_r <= wdata[serial_port_zero_pkg::CTL_RX9];
			end
			if (fe_set) begin
				fe_r <= 1'b1;
			end else if (wr_ctl && fe_en_r) begin
				fe_r <= wdata[serial_port_zero_pkg::CTL_MODE_HI];
			end
			if (tx_done_set) begin
				tx_done_r <= 1'b1;
			end else if (wr_ctl) begin
				tx_done_r <= wdata[serial_port_zero_pkg::CTL_TX_DONE];
			end
			if (rx_done_set) begin
				rx_done_r <= 1'b1;
				rx_buf_r <= is_async ? rx_data_a : m0_sh_r;
			end else if (wr_ctl) begin
				rx_done_r <= wdata[serial_port_zero_pkg::CTL_RX_DONE];
			end
			if (wr_pwr) begin
				doubler_r <= wdata[serial_port_zero_pkg::PWR_DOUBLER];
				fe_en_r <= wdata[serial_port_zero_pkg::PWR_FE_EN];
			end
			if (wr_baud) begin
				baud_r <= hwdata[15:0];
			end
			if (wr_msk) begin
				msk_r <= wdata[2:0];
			end
			sts_r <= (sts_r & ~(wr_sts ? wdata[2:0] : 3'h0))
				| {fe_set, rx_done_set, tx_done_set};
			irq <= |(sts_r & msk_r);
			txd <= is_async ? tx_bit_r : m0_clk_r;
			rxd_out <= m0_out_r;
			rxd_oe <= m0_oe_r;
		end
	end
endmodule
`default_nettype wire

//--- include/serial_port_zero_pkg.sv
// Constants, types and register map of the serial port zero block
package serial_port_zero_pkg;
	localparam logic [7:0] OFF_CONTROL = 8'h98;
	localparam logic [7:0] OFF_BUFFER = 8'h9c;
	localparam logic [7:0] OFF_POWER = 8'ha0;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'ha4;
	localparam logic [7:0] OFF_IRQ_MASK = 8'ha8;
	localparam logic [7:0] OFF_BAUD = 8'hac;
	localparam int CTL_MODE_HI = 7;
	localparam int CTL_MODE_LO = 6;
	localparam int CTL_FILTER = 5;
	localparam int CTL_RX_EN = 4;
	localparam int CTL_TX9 = 3;
	localparam int CTL_RX9 = 2;
	localparam int CTL_TX_DONE = 1;
	localparam int CTL_RX_DONE = 0;
	localparam int PWR_DOUBLER = 7;
	localparam int PWR_FE_EN = 6;
	localparam int IRQ_TX = 0;
	localparam int IRQ_RX = 1;
	localparam int IRQ_FE = 2;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] POWER_RESET = 8'h00;
	localparam logic [2:0] IRQ_RESET = 3'h0;
	localparam logic [15:0] BAUD_RESET = 16'h00d9;
	localparam logic [16:0] MODE0_HALF_SLOW = 17'h00006;
	localparam logic [16:0] MODE0_HALF_FAST = 17'h00002;
	localparam logic [16:0] MODE2_BIT_NORMAL = 17'h00040;
	localparam logic [16:0] MODE2_BIT_DOUBLE = 17'h00020;
	localparam logic [3:0] FRAME_LEN_10 = 4'ha;
	localparam logic [3:0] FRAME_LEN_11 = 4'hb;
	localparam logic [3:0] DATA_LEN_8 = 4'h8;
	localparam logic [3:0] DATA_LEN_9 = 4'h9;
	localparam logic [2:0] SHIFT_LAST = 3'h7;
	typedef enum logic [1:0] {
		MODE_SHIFT = 2'b00,
		MODE_ASYNC8 = 2'b01,
		MODE_ASYNC9_FIXED = 2'b10,
		MODE_ASYNC9_VAR = 2'b11
	} mode_t;
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b10,
		RX_STOP = 2'b11
	} rx_state_t;
	typedef struct packed {
		logic [7:0] addr;
		logic write;
		logic valid;
	} ahb_req_t;
endpackage
